/* File: hdl/bbp_pkg.sv */
// constants, types and lane maps for the baseband double-rate lane port
`default_nettype none
package bbp_pkg;

  localparam int LANES    = 12;
  localparam int SYM_BITS = 9;

  // limits on the far side's forwarded input clock, in MHz
  localparam int IN_CLK_MAX_NIB0_MHZ = 500;
  localparam int IN_CLK_MAX_MHZ      = 384;
  localparam int IN_CLK_MAX_ALT_MHZ  = 250;

  // output clock ceilings per mode, in MHz
  localparam logic [9:0] OUT_FULL_MAX_MHZ    = 10'h136;
  localparam logic [9:0] OUT_HALF_MAX_MHZ    = 10'h09b;
  localparam logic [9:0] OUT_CENTRED_MAX_MHZ = 10'h0fa;

  // one core clock cycle stands for half an internal clock period
  localparam logic [1:0] FULL_LAST   = 2'h1;
  localparam logic [1:0] HALF_LAST   = 2'h3;
  localparam logic [1:0] FULL_TOGGLE = 2'h0;
  localparam logic [1:0] HALF_TOGGLE = 2'h1;

  typedef enum logic [1:0] {
    BBP_EDGE = 2'h0,
    BBP_FULL = 2'h1,
    BBP_HALF = 2'h3
  } bbp_mode_t;

  typedef enum logic [2:0] {
    BBP_SER0 = 3'h0,
    BBP_SER1 = 3'h1,
    BBP_SER2 = 3'h3,
    BBP_NIB0 = 3'h2,
    BBP_NIB1 = 3'h6,
    BBP_BYTE = 3'h7
  } bbp_group_t;

  typedef enum logic {
    BBP_TX_IDLE = 1'b0,
    BBP_TX_SEND = 1'b1
  } bbp_tx_t;

  typedef struct packed {
    logic                frame;
    logic [SYM_BITS-1:0] data;
  } bbp_sym_t;

  localparam bbp_sym_t SYM_RESET = '0;

  function automatic logic [3:0] bbpClkLane(bbp_group_t g);
    case (g)
      BBP_SER0, BBP_NIB0: return 4'h3;
      BBP_SER2:           return 4'hb;
      default:            return 4'h7;
    endcase
  endfunction

  // frame/sync lane sits just below the clock lane in every grouping
  function automatic logic [3:0] bbpFrameLane(bbp_group_t g);
    return bbpClkLane(g) - 4'h1;
  endfunction

  function automatic logic [3:0] bbpDataBits(bbp_group_t g);
    case (g)
      BBP_NIB0, BBP_NIB1: return 4'h4;
      BBP_BYTE:           return 4'h9;
      default:            return 4'h2;
    endcase
  endfunction

  function automatic logic [3:0] bbpDataLane(bbp_group_t g, logic [3:0] i);
    case (g)
      BBP_SER1: return i + 4'h4;
      BBP_SER2, BBP_NIB1: return i + 4'h8;
      BBP_NIB0: return (i < 4'h2) ? i : i + 4'h2;
      BBP_BYTE: return (i < 4'h3) ? i : ((i < 4'h5) ? i + 4'h1 : i + 4'h3);
      default:  return i;
    endcase
  endfunction

endpackage
`default_nettype wire

/* File: hdl/bbp_fifo.sv */
// small valid/ready buffer with registered flags
`timescale 1ns/1ps
`default_nettype none
module bbp_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output var  logic             inReady_q,
  // drain side
  output logic      [WIDTH-1:0] outData,
  output var  logic             outValid_q,
  input  wire logic             outReady
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [IW-1:0] LAST_IDX = IW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [IW-1:0]    wr_q;
  logic [IW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;
  wire              push = inValid && inReady_q;
  wire              pop  = outValid_q && outReady;

  assign outData = mem_q[rd_q];
  assign cnt_d   = cnt_q + CW'(push) - CW'(pop);

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= inData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_q       <= '0;
      rd_q       <= '0;
      cnt_q      <= '0;
      inReady_q  <= 1'b0;
      outValid_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_IDX) ? '0 : wr_q + IW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_IDX) ? '0 : rd_q + IW'(1);
      end
      cnt_q      <= cnt_d;
      inReady_q  <= cnt_d != FULL_CNT;
      outValid_q <= cnt_d != '0;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/bbp_in_capture.sv */
// input lane synchroniser and both-edge sample capture
`timescale 1ns/1ps
`default_nettype none
module bbp_in_capture (
  // clock and reset
  input  wire logic                           clock,
  input  wire logic                           rst,
  // configuration
  input  wire bbp_pkg::bbp_group_t            group,
  // link pins
  input  wire logic [bbp_pkg::LANES-1:0]      lanes,
  // captured samples
  output var  bbp_pkg::bbp_sym_t              sym_q,
  output var  logic                           symValid_q
);
  logic [bbp_pkg::LANES-1:0]    meta_q;
  logic [bbp_pkg::LANES-1:0]    sync_q;
  logic [bbp_pkg::LANES-1:0]    last_q;
  logic [bbp_pkg::SYM_BITS-1:0] bits;
  wire  [3:0]                   clkLane = bbp_pkg::bbpClkLane(group);
  wire  [3:0]                   nBits   = bbp_pkg::bbpDataBits(group);
  wire                          clkEdge = sync_q[clkLane] != last_q[clkLane];

  // unused symbol bits read zero so the user sees a clean word
  for (genvar b = 0; b < bbp_pkg::SYM_BITS; b++) begin : g_bit
    assign bits[b] = (4'(b) < nBits) ?
                     sync_q[bbp_pkg::bbpDataLane(group, 4'(b))] : 1'b0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q     <= '0;
      sync_q     <= '0;
      last_q     <= '0;
      sym_q      <= bbp_pkg::SYM_RESET;
      symValid_q <= 1'b0;
    end else begin
      meta_q     <= lanes;
      sync_q     <= meta_q;
      last_q     <= sync_q;
      symValid_q <= clkEdge;
      if (clkEdge) begin
        sym_q <= '{frame: sync_q[bbp_pkg::bbpFrameLane(group)], data: bits};
      end
    end
  end

  property p_both_edges;
    @(posedge clock) disable iff (rst)
    ($rose(sync_q[clkLane]) || $fell(sync_q[clkLane])) && $stable(group) |=> symValid_q;
  endproperty
  a_both_edges: assert property (p_both_edges) else $error("forwarded clock edge not captured");

  property p_serial0_map;
    @(posedge clock) disable iff (rst)
    symValid_q && group == bbp_pkg::BBP_SER0 && $stable(group) |->
      sym_q.data == {7'h00, $past(sync_q[1:0])} && sym_q.frame == $past(sync_q[2]);
  endproperty
  a_serial0_map: assert property (p_serial0_map) else $error("serial group 0 lanes wrong");

  property p_byte_map;
    @(posedge clock) disable iff (rst)
    symValid_q && group == bbp_pkg::BBP_BYTE && $stable(group) |->
      sym_q.data == {$past(sync_q[11:8]), $past(sync_q[5:4]), $past(sync_q[2:0])} &&
      sym_q.frame == $past(sync_q[6]);
  endproperty
  a_byte_map: assert property (p_byte_map) else $error("byte grouping lanes wrong");
endmodule
`default_nettype wire

/* File: hdl/bbp_port.sv */
// baseband lane port: both-edge input capture and three-mode output lanes
`timescale 1ns/1ps
`default_nettype none
module bbp_port #(
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // configuration
  input  wire bbp_pkg::bbp_mode_t           cfgMode,
  input  wire bbp_pkg::bbp_group_t          cfgGroup,
  input  wire logic [9:0]                   outClkMhz,
  // link pins
  input  wire logic [bbp_pkg::LANES-1:0]    basebandInputLanes,
  output var  logic [bbp_pkg::LANES-1:0]    basebandOutputLanes_q,
  // received samples towards user logic
  output bbp_pkg::bbp_sym_t                 rxSym,
  output var  logic                         rxValid_q,
  input  wire logic                         rxReady,
  // samples to send from user logic
  input  wire bbp_pkg::bbp_sym_t            txSym,
  input  wire logic                         txValid,
  output var  logic                         txReady_q,
  // status
  output var  logic                         overrun_q,
  output var  logic                         modeMismatch_q,
  output var  logic                         busy_q
);
  // configuration held while any word is in flight
  bbp_pkg::bbp_mode_t  mode_q;
  bbp_pkg::bbp_group_t group_q;

  // input capture and receive buffer
  bbp_pkg::bbp_sym_t capSym;
  logic              capValid;
  logic              rxInReady;

  bbp_in_capture u_cap (
    .clock      (clock),
    .rst        (rst),
    .group      (group_q),
    .lanes      (basebandInputLanes),
    .sym_q      (capSym),
    .symValid_q (capValid)
  );

  // the link cannot be stalled, so a full buffer drops the word and flags it
  bbp_fifo #(
    .WIDTH (bbp_pkg::SYM_BITS + 1),
    .DEPTH (BUF_DEPTH)
  ) u_rxbuf (
    .clock      (clock),
    .rst        (rst),
    .inData     (capSym),
    .inValid    (capValid),
    .inReady_q  (rxInReady),
    .outData    (rxSym),
    .outValid_q (rxValid_q),
    .outReady   (rxReady)
  );

  // transmit buffer
  bbp_pkg::bbp_sym_t txHead;
  logic              txHeadValid;
  logic              txLoad;

  bbp_fifo #(
    .WIDTH (bbp_pkg::SYM_BITS + 1),
    .DEPTH (BUF_DEPTH)
  ) u_txbuf (
    .clock      (clock),
    .rst        (rst),
    .inData     (txSym),
    .inValid    (txValid),
    .inReady_q  (txReady_q),
    .outData    (txHead),
    .outValid_q (txHeadValid),
    .outReady   (txLoad)
  );

  // output sequencer
  bbp_pkg::bbp_tx_t  txState_q;
  bbp_pkg::bbp_tx_t  txState_d;
  logic [1:0]        cnt_q;
  logic [1:0]        cnt_d;
  bbp_pkg::bbp_sym_t sym_q;
  logic              clk_q;
  logic              clkToggle;

  wire       isEdge   = mode_q == bbp_pkg::BBP_EDGE;
  wire       isHalf   = mode_q == bbp_pkg::BBP_HALF;
  wire [1:0] lastCnt  = isEdge ? 2'h0 :
                        (isHalf ? bbp_pkg::HALF_LAST : bbp_pkg::FULL_LAST);
  wire [1:0] togCnt   = isHalf ? bbp_pkg::HALF_TOGGLE : bbp_pkg::FULL_TOGGLE;
  wire       sending  = txState_q == bbp_pkg::BBP_TX_SEND;
  wire       bitDone  = !sending || cnt_q == lastCnt;
  wire       idle     = !sending && !txHeadValid && !rxValid_q && !capValid;

  // a new word starts only once the previous one has had its full bit time
  assign txLoad    = bitDone && txHeadValid;
  // edge mode moves the clock with the data, centred modes half a bit later
  assign clkToggle = isEdge ? txLoad :
                     (sending && cnt_q == togCnt);
  assign cnt_d     = txLoad ? 2'h0 : (sending && !bitDone) ? cnt_q + 2'h1 : cnt_q;
  assign txState_d = txLoad ? bbp_pkg::BBP_TX_SEND :
                     (bitDone ? bbp_pkg::BBP_TX_IDLE : txState_q);

  // lane placement of clock, frame and data for the held grouping
  function automatic logic [bbp_pkg::LANES-1:0] laneMap(
    bbp_pkg::bbp_group_t g, bbp_pkg::bbp_sym_t s, logic c);
    logic [bbp_pkg::LANES-1:0] v;
    v = '0;
    for (int k = 0; k < bbp_pkg::SYM_BITS; k++) begin
      if (4'(k) < bbp_pkg::bbpDataBits(g)) begin
        v[bbp_pkg::bbpDataLane(g, 4'(k))] = s.data[k];
      end
    end
    v[bbp_pkg::bbpFrameLane(g)] = s.frame;
    v[bbp_pkg::bbpClkLane(g)]   = c;
    return v;
  endfunction

  wire [bbp_pkg::LANES-1:0] laneNext = laneMap(group_q, sym_q, clk_q);

  // rate check against the clock the user plans to run
  wire mismatch = (isHalf && outClkMhz > bbp_pkg::OUT_HALF_MAX_MHZ) ||
                  (mode_q == bbp_pkg::BBP_FULL && outClkMhz > bbp_pkg::OUT_FULL_MAX_MHZ) ||
                  (!isEdge && outClkMhz > bbp_pkg::OUT_CENTRED_MAX_MHZ);

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q  <= bbp_pkg::BBP_HALF;
      group_q <= bbp_pkg::BBP_SER0;
    end else if (idle) begin
      mode_q  <= cfgMode;
      group_q <= cfgGroup;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      txState_q <= bbp_pkg::BBP_TX_IDLE;
      cnt_q     <= 2'h0;
      sym_q     <= bbp_pkg::SYM_RESET;
      clk_q     <= 1'b0;
    end else begin
      txState_q <= txState_d;
      cnt_q     <= cnt_d;
      if (txLoad) begin
        sym_q <= txHead;
      end
      if (clkToggle) begin
        clk_q <= !clk_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      basebandOutputLanes_q <= '0;
      overrun_q             <= 1'b0;
      modeMismatch_q        <= 1'b0;
      busy_q                <= 1'b0;
    end else begin
      basebandOutputLanes_q <= laneNext;
      overrun_q             <= overrun_q || (capValid && !rxInReady);
      modeMismatch_q        <= mismatch;
      busy_q                <= !idle;
    end
  end

  // assertions
  property p_half_timing;
    @(posedge clock) disable iff (rst)
    txLoad && isHalf |=> !clkToggle ##1 clkToggle;
  endproperty
  a_half_timing: assert property (p_half_timing) else $error("half-rate clock not one edge later");

  property p_full_timing;
    @(posedge clock) disable iff (rst)
    txLoad && mode_q == bbp_pkg::BBP_FULL |=> clkToggle && !txLoad;
  endproperty
  a_full_timing: assert property (p_full_timing) else $error("full-rate clock not between data");

  property p_centred;
    @(posedge clock) disable iff (rst)
    !isEdge && clkToggle |-> !txLoad;
  endproperty
  a_centred: assert property (p_centred) else $error("centred clock moved with data");

  property p_edge_aligned;
    @(posedge clock) disable iff (rst)
    isEdge && txLoad |-> clkToggle ##1 (clk_q != $past(clk_q));
  endproperty
  a_edge_aligned: assert property (p_edge_aligned) else $error("edge mode clock not with data");

  property p_half_bit_time;
    @(posedge clock) disable iff (rst)
    txLoad && isHalf |=> !txLoad [*3];
  endproperty
  a_half_bit_time: assert property (p_half_bit_time) else $error("half-rate bit shorter than 4");

  property p_cfg_hold;
    @(posedge clock) disable iff (rst)
    sending || txHeadValid |=> $stable(mode_q) && $stable(group_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed mid transfer");

  property p_frame_lane;
    @(posedge clock) disable iff (rst)
    $stable(group_q) |=>
      basebandOutputLanes_q[bbp_pkg::bbpFrameLane(bbp_pkg::bbp_group_t'($past(group_q)))] ==
      $past(sym_q.frame);
  endproperty
  a_frame_lane: assert property (p_frame_lane) else $error("frame lane not timed with data");

  property p_clk_lane;
    @(posedge clock) disable iff (rst)
    $stable(group_q) |=>
      basebandOutputLanes_q[bbp_pkg::bbpClkLane(bbp_pkg::bbp_group_t'($past(group_q)))] ==
      $past(clk_q);
  endproperty
  a_clk_lane: assert property (p_clk_lane) else $error("clock lane misplaced");

  property p_mismatch;
    @(posedge clock) disable iff (rst)
    !isEdge && outClkMhz > bbp_pkg::OUT_CENTRED_MAX_MHZ |=> modeMismatch_q;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("fast clock in centred mode not flagged");
endmodule
`default_nettype wire

/* File: bench/bbp_tb_pkg.sv */
// bench-side lane maps for every grouping
`default_nettype none
package bbp_tb_pkg;

  // one nibble per entry: data lanes from bit 0 up, then frame lane, then clock lane
  function automatic logic [47:0] tbl(bbp_pkg::bbp_group_t g);
    case (g)
      bbp_pkg::BBP_SER0: return 48'h3210;
      bbp_pkg::BBP_SER1: return 48'h7654;
      bbp_pkg::BBP_SER2: return 48'hba98;
      bbp_pkg::BBP_NIB0: return 48'h325410;
      bbp_pkg::BBP_NIB1: return 48'h76ba98;
      default:           return 48'h076ba9854210;
    endcase
  endfunction

  function automatic int wid(bbp_pkg::bbp_group_t g);
    case (g)
      bbp_pkg::BBP_NIB0, bbp_pkg::BBP_NIB1: return 4;
      bbp_pkg::BBP_BYTE:                    return 9;
      default:                              return 2;
    endcase
  endfunction

  function automatic int lane(bbp_pkg::bbp_group_t g, int k);
    logic [47:0] t;
    t = tbl(g);
    return int'(t[4*k +: 4]);
  endfunction

  // data and frame lanes of one symbol; clock and unused lanes stay 0
  function automatic logic [11:0] place(bbp_pkg::bbp_group_t g, bbp_pkg::bbp_sym_t s);
    logic [11:0] v;
    int          n;
    v = 12'h000;
    n = wid(g);
    for (int k = 0; k < n; k++) v[lane(g, k)] = s.data[k];
    v[lane(g, n)] = s.frame;
    return v;
  endfunction

endpackage
`default_nettype wire

/* File: bench/bbp_partner.sv */
// baseband source model driving the link input lanes
`timescale 1ns/1ps
`default_nettype none
module bbp_partner (
  // link pins
  output var logic [11:0] lanes
);
  initial lanes = 12'h000;

  // 125 ns link period stays under every input clock ceiling
  task automatic sendWord(bbp_pkg::bbp_group_t g, bbp_pkg::bbp_sym_t s);
    int c;
    c = bbp_tb_pkg::lane(g, bbp_tb_pkg::wid(g) + 1);
    lanes = bbp_tb_pkg::place(g, s) | (lanes & (12'h001 << c));
    #31.0;
    lanes[c] = ~lanes[c];
    #31.5;
  endtask

  // hold time over: data shows its inverse, clock lane stands still
  task automatic endFrame(bbp_pkg::bbp_group_t g);
    lanes = lanes ^ bbp_tb_pkg::place(g, 10'h3ff);
  endtask
endmodule
`default_nettype wire

/* File: bench/bbp_port_tb.sv */
// self-checking bench for the baseband lane port
`timescale 1ns/1ps
`default_nettype none
module bbp_port_tb;
  localparam bbp_pkg::bbp_sym_t W1 = 10'h2a5;
  logic                clock;
  logic                rst;
  bbp_pkg::bbp_mode_t  cfgMode;
  bbp_pkg::bbp_group_t cfgGroup;
  logic [9:0]          outClkMhz;
  logic [11:0]         inLanes;
  logic [11:0]         outLanes;
  bbp_pkg::bbp_sym_t   rxSym;
  logic                rxValid;
  logic                rxReady;
  bbp_pkg::bbp_sym_t   txSym;
  logic                txValid;
  logic                txReady;
  logic                overrun;
  logic                mismatch;
  logic                busy;
  bbp_pkg::bbp_group_t grp[6];
  int                  fail_count;
  int                  samples_checked;

  bbp_port #(.BUF_DEPTH(2)) DUT (
    .clock(clock), .rst(rst), .cfgMode(cfgMode), .cfgGroup(cfgGroup),
    .outClkMhz(outClkMhz), .basebandInputLanes(inLanes),
    .basebandOutputLanes_q(outLanes), .rxSym(rxSym), .rxValid_q(rxValid),
    .rxReady(rxReady), .txSym(txSym), .txValid(txValid), .txReady_q(txReady),
    .overrun_q(overrun), .modeMismatch_q(mismatch), .busy_q(busy)
  );

  bbp_partner partner (.lanes(inLanes));

  initial clock = 1'b0;
  always #2 clock = ~clock;

  task automatic check(string what, logic [11:0] seen, logic [11:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic bbp_pkg::bbp_sym_t rxWant(bbp_pkg::bbp_group_t g, bbp_pkg::bbp_sym_t s);
    return s & {1'b1, 9'((1 << bbp_tb_pkg::wid(g)) - 1)};
  endfunction

  task automatic resetDut();
    rst = 1'b1;
    repeat (6) @(negedge clock);
    check("ready in reset", txReady, 1'b0);
    check("valid in reset", rxValid, 1'b0);
    check("overrun in reset", overrun, 1'b0);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    check("ready after reset", txReady, 1'b1);
  endtask

  // configuration only moves while the port is idle
  task automatic idleCfg(bbp_pkg::bbp_mode_t m, bbp_pkg::bbp_group_t g);
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 200) begin
      @(negedge clock);
      i++;
    end
    check("idle", busy, 1'b0);
    cfgMode = m;
    cfgGroup = g;
    repeat (3) @(negedge clock);
  endtask

  task automatic push(bbp_pkg::bbp_sym_t s);
    txSym = s;
    txValid = 1'b1;
    while (txReady !== 1'b1) @(negedge clock);
    @(negedge clock);
  endtask

  task automatic mm(bbp_pkg::bbp_mode_t m, logic [9:0] f, logic want);
    idleCfg(m, bbp_pkg::BBP_SER0);
    outClkMhz = f;
    repeat (2) @(negedge clock);
    check("mode mismatch", mismatch, want);
  endtask

  // lanes are read at the falling edge, half a cycle after launch
  task automatic txCheck(bbp_pkg::bbp_mode_t m, bbp_pkg::bbp_group_t g, int per);
    logic [11:0] cb;
    logic [11:0] e1;
    logic        c0;
    int          n;
    int          flip;
    int          i;
    cb = 12'h001 << bbp_tb_pkg::lane(g, bbp_tb_pkg::wid(g) + 1);
    e1 = bbp_tb_pkg::place(g, W1);
    idleCfg(m, g);
    c0 = |(outLanes & cb);
    push(W1);
    push(~W1);
    push(W1);
    txValid = 1'b0;
    // a mode change in mid-transfer must not take effect
    cfgMode = bbp_pkg::BBP_EDGE;
    i = 0;
    while (per == 4 && txReady === 1'b1 && i < 4) begin
      @(negedge clock);
      i++;
    end
    if (per == 4)
      check("tx full", txReady, 1'b0);
    i = 0;
    while ((outLanes & ~cb) !== e1 && i < 20) begin
      @(negedge clock);
      i++;
    end
    n = 0;
    flip = -1;
    while ((outLanes & ~cb) === e1 && n < 8) begin
      if (flip < 0 && |(outLanes & cb) != c0)
        flip = n;
      n++;
      @(negedge clock);
    end
    check("stand", 12'(n), 12'(per));
    check("clock edge", 12'(flip), 12'(per / 2));
    check("next word", outLanes & ~cb, bbp_tb_pkg::place(g, ~W1));
  endtask

  task automatic pop(bbp_pkg::bbp_sym_t want);
    int i;
    i = 0;
    while (rxValid !== 1'b1 && i < 50) begin
      @(negedge clock);
      i++;
    end
    check("rx word", rxSym, want);
    rxReady = 1'b1;
    @(negedge clock);
    rxReady = 1'b0;
    @(negedge clock);
  endtask

  task automatic rxCheck(bbp_pkg::bbp_group_t g, int words);
    idleCfg(bbp_pkg::BBP_HALF, g);
    for (int k = 0; k < words; k++) begin
      partner.sendWord(g, (k % 2) ? ~W1 : W1);
    end
    partner.endFrame(g);
    repeat (8) @(negedge clock);
    check("overrun", overrun, words > 2);
    pop(rxWant(g, W1));
    pop(rxWant(g, ~W1));
    check("drained", rxValid, 1'b0);
  endtask

  initial begin
    #100000;
    fail_count++;
    summarize();
  end

  initial begin
    fail_count = 0;
    samples_checked = 0;
    grp = '{bbp_pkg::BBP_SER0, bbp_pkg::BBP_SER1, bbp_pkg::BBP_SER2,
            bbp_pkg::BBP_NIB0, bbp_pkg::BBP_NIB1, bbp_pkg::BBP_BYTE};
    cfgMode = bbp_pkg::BBP_HALF;
    cfgGroup = bbp_pkg::BBP_SER0;
    outClkMhz = 10'h000;
    rxReady = 1'b0;
    txSym = 10'h000;
    txValid = 1'b0;
    resetDut();
    mm(bbp_pkg::BBP_HALF, 10'h09b, 1'b0);
    mm(bbp_pkg::BBP_HALF, 10'h09c, 1'b1);
    mm(bbp_pkg::BBP_FULL, 10'h0fa, 1'b0);
    mm(bbp_pkg::BBP_FULL, 10'h0fb, 1'b1);
    mm(bbp_pkg::BBP_FULL, 10'h136, 1'b1);
    mm(bbp_pkg::BBP_EDGE, 10'h190, 1'b0);
    for (int g = 0; g < 6; g++) begin
      rxCheck(grp[g], 2);
      txCheck(bbp_pkg::BBP_EDGE, grp[g], 1);
      txCheck(bbp_pkg::BBP_FULL, grp[g], 2);
      txCheck(bbp_pkg::BBP_HALF, grp[g], 4);
    end
    // receiver stalls: two words fill the buffer, the next two are dropped
    rxCheck(bbp_pkg::BBP_SER0, 4);
    resetDut();
    summarize();
  end
endmodule
`default_nettype wire
